// file: logic/eic_pkg.sv
// shared constants for the error insertion countdown block
package eic_pkg;
  localparam int          CNT_W          = 32;
  localparam int          ACC_W          = 8;
  localparam int          TICK_DIV       = 1;
  localparam int          CCNT_W         = 8;
  // register byte offsets
  localparam logic [7:0]  OFS_CAP        = 8'h00;
  localparam logic [7:0]  OFS_CTRL       = 8'h04;
  localparam logic [7:0]  OFS_RELOAD     = 8'h08;
  localparam logic [7:0]  OFS_RCTRL      = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;
  localparam logic [7:0]  OFS_FEAT       = 8'h14;
  localparam logic [7:0]  OFS_ARCH       = 8'h18;
  // insertion_control_reg fields
  localparam int          SEL_CORR       = 0;
  localparam int          SEL_POST       = 1;
  localparam int          SEL_UNC        = 2;
  localparam int          CTL_POISON     = 3;
  localparam int          CTL_RESTART    = 4;
  localparam int          CTL_CRIT       = 5;
  localparam int          CTL_KIND_LO    = 6;
  localparam int          CTL_REPEAT     = 30;
  localparam int          CTL_RUN        = 31;
  localparam logic [31:0] CTRL_MASK      = 32'hc000_00ff;
  // record_control_reg fields
  localparam int          RC_LOG         = 0;
  localparam int          RC_FH_UNC      = 1;
  localparam int          RC_FH_CORR     = 2;
  localparam int          RC_RECOV_UNC   = 3;
  localparam int          RC_RECOV_POST  = 4;
  localparam int          RC_CRIT        = 5;
  localparam int          RC_INBAND      = 6;
  localparam logic [31:0] RCTRL_MASK     = 32'h0000_007f;
  // record status fields
  localparam int          ST_VALID       = 0;
  localparam int          ST_UNC         = 1;
  localparam int          ST_POST        = 2;
  localparam int          ST_CRIT        = 3;
  localparam int          ST_RESTART     = 4;
  localparam int          ST_POISON      = 5;
  localparam int          ST_KIND_LO     = 6;
  localparam int          ST_CCNT_LO     = 8;
  // capability and feature fields
  localparam int          CAP_ON_ACCESS  = 0;
  localparam int          CAP_TYPES_LO   = 1;
  localparam int          CAP_POISON     = 4;
  localparam int          CAP_RESTART    = 5;
  localparam int          CAP_CRIT       = 6;
  localparam int          CAP_REPEAT     = 7;
  localparam int          FT_PRESENT     = 0;
  localparam logic [3:0]  ARCH_REVISION  = 4'h1;
  localparam logic [3:0]  INSERT_MIN_REV = 4'h1;
  // reset values
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] RELOAD_RST     = 32'h0000_0000;
  localparam logic [31:0] RCTRL_RST      = 32'h0000_0001;
  localparam logic [15:0] STATUS_RST     = 16'h0000;

  typedef enum logic [1:0] {
    CD_IDLE   = 2'b00,
    CD_COUNT  = 2'b01,
    CD_INJECT = 2'b10
  } eic_cd_state_type;
endpackage

// file: logic/eic_cnt_if.sv
// link between register side and countdown engine
`timescale 1ns/1ps
`default_nettype none
interface eic_cnt_if;
  logic                     run;
  logic                     repeat_on;
  logic                     enable;
  logic                     load_pulse;
  logic                     inject_done;
  logic                     in_state;
  logic [eic_pkg::CNT_W-1:0] reload;

  modport ctl (output run, repeat_on, enable, load_pulse, inject_done, reload, input in_state);
  modport cnt (input run, repeat_on, enable, load_pulse, inject_done, reload, output in_state);
endinterface
`default_nettype wire

// file: logic/eic_countdown.sv
// generation counter and fault injection state
`timescale 1ns/1ps
`default_nettype none
module eic_countdown #(
  parameter int W   = eic_pkg::CNT_W,
  parameter int DIV = eic_pkg::TICK_DIV
) (
  input  wire logic clk,
  input  wire logic rst,
  eic_cnt_if.cnt    cif
);
  import eic_pkg::*;

  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

  logic [15:0]      div_reg;
  logic [W-1:0]     cnt_reg;
  logic [W-1:0]     reload_w;
  logic             tick;
  logic             hit;
  eic_cd_state_type state_reg;
  eic_cd_state_type state_next;

  assign reload_w = cif.reload[W-1:0];
  assign tick     = (div_reg == DIV_LAST);
  // the decrement that lands on zero this cycle
  assign hit      = tick && cif.run && cif.enable && (cnt_reg == W'(1)) && !cif.load_pulse;
  assign cif.in_state = (state_reg == CD_INJECT);

  // countdown clock: one-cycle enable every DIV cycles
  always_ff @(posedge clk)
  begin
    if (rst || div_reg == DIV_LAST)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end

  // other run writes leave the counter as it is
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (cif.load_pulse && reload_w != '0)
      cnt_reg <= reload_w; // R6 R7
    else if (cnt_reg == '0)
    begin
      if (cif.repeat_on && cif.run && reload_w != '0)
        cnt_reg <= reload_w; // R22
    end
    else if (tick && cif.run && cif.enable)
      cnt_reg <= cnt_reg - W'(1); // R9 R23
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CD_IDLE, CD_COUNT:
        if (hit)
          state_next = CD_INJECT; // R10
        else if (cif.run && cnt_reg != '0)
          state_next = CD_COUNT;
        else
          state_next = CD_IDLE;
      CD_INJECT:
        // clearing run or disabling logging abandons a pending injection
        if (cif.inject_done || !cif.run || !cif.enable)
          state_next = (cif.run && cnt_reg != '0) ? CD_COUNT : CD_IDLE; // R13 R14 R5
      default:
        state_next = CD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_reg <= CD_IDLE;
    else
      state_reg <= state_next;
  end

  a_load_on_start: assert property (@(posedge clk) disable iff (rst) // R6
    cif.load_pulse && cif.reload != '0 |=> cnt_reg == $past(reload_w))
    else $error("counter not loaded on run start");

  a_count_step: assert property (@(posedge clk) disable iff (rst) // R9
    tick && cif.run && cif.enable && cnt_reg > W'(1) && !cif.load_pulse |=> cnt_reg == $past(cnt_reg) - W'(1))
    else $error("counter did not step by one");

  a_zero_enters: assert property (@(posedge clk) disable iff (rst) // R10
    hit |=> cif.in_state && cnt_reg == '0)
    else $error("reaching zero did not enter injection state");

  a_repeat_reload: assert property (@(posedge clk) disable iff (rst) // R22
    cnt_reg == '0 && cif.repeat_on && cif.run && reload_w != '0 |=> cnt_reg == $past(reload_w))
    else $error("repeat did not reload counter");
endmodule // eic_countdown
`default_nettype wire

// file: logic/eic_fault_inject.sv
// fault insertion unit with its error record and Avalon-MM register slave
//
// What this block does
// R1: Insertion exists only when the group architecture revision is at least one.
// R2: Faked detection drives fault, recovery interrupts and in-band response like real errors.
// R3: Insertion only fakes detection; no held or transferred data is corrupted.
// R4: Only recordable error types may be injected; unsupported selections inject nothing.
// R5: Insertion is disabled while writable logging_on holds zero.
// R6: Setting countdown_run from zero with nonzero reload loads the generation counter.
// R7: Any other countdown_run write may leave counter and state unchanged.
// R8: The generation counter is never readable by software.
// R9: While running and nonzero, the counter decrements once per countdown tick.
// R10: Decrementing to zero enters the fault injection state.
// R11: In injection state, fake the selected error, report it, record if logging.
// R12: With logging disabled the injected error may or may not be recorded.
// R13: Inject on next access or spontaneously per inject_on_access, then leave state.
// R14: Clearing countdown_run in injection state may leave or keep that state.
// R15: Recording sets valid, uncorrected, corrected count, postponed and kind from control.
// R16: Zero or several selected types inject nothing or an arbitrary type.
// R17: Other syndrome updates are chosen; insertion_capability_reg describes the options.
// R18: Poison only with uncorrected or postponed, restartable only with uncorrected.
// R19: Insertion registers live in the first record, which records the injection.
// R20: Edge interrupts fire for injected errors exactly as for detected ones.
// R21: Level interrupts depend only on control and status field values.
// R22: At zero with repeat set, reload from nonzero countdown_reload.
// R23: The generation counter is as wide as countdown_reload.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module eic_fault_inject #(
  parameter logic [2:0] SUPPORTED_TYPES  = 3'h7,
  parameter bit         INJECT_ON_ACCESS = 1'b1,
  parameter bit         LOGGING_WRITABLE = 1'b1,
  parameter int         DIV              = eic_pkg::TICK_DIV
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [eic_pkg::ACC_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      acc_req,
  output logic                           acc_ack,
  output logic                           acc_err,
  output logic                           fault_irq,
  output logic                           recov_irq,
  output logic                           crit_irq
);
  import eic_pkg::*;

  // one record only, so this record always holds the injected syndrome
  localparam bit PRESENT = (ARCH_REVISION >= INSERT_MIN_REV); // R1 R19

  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic [31:0] rd_mux;
  logic [31:0] wmerged;
  logic        wr_fire;
  logic [31:0] ctrl_reg;
  logic [31:0] reload_reg;
  logic [31:0] rctrl_reg;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic        fault_irq_reg;
  logic        recov_irq_reg;
  logic        crit_irq_reg;
  logic [2:0]  sel;
  logic        logging_on;
  logic        onehot;
  logic        req_ok;
  logic        ins_go;
  logic        record;
  logic [31:0] cap_value;

  eic_cnt_if cif ();

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  // bus slave: one wait cycle on every access
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_fire         = avs_write && ack_reg;
  assign avs_readdata    = readdata_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read || avs_write) && !ack_reg;
  end

  always_comb
  begin
    case (avs_address)
      OFS_CAP:    wmerged = be_merge(cap_value, avs_writedata, avs_byteenable);
      OFS_CTRL:   wmerged = be_merge(ctrl_reg, avs_writedata, avs_byteenable);
      OFS_RELOAD: wmerged = be_merge(reload_reg, avs_writedata, avs_byteenable);
      OFS_RCTRL:  wmerged = be_merge(rctrl_reg, avs_writedata, avs_byteenable);
      default:    wmerged = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
    endcase
  end

  // the counter itself has no read path
  always_comb
  begin
    case (avs_address)
      OFS_CAP:    rd_mux = cap_value;
      OFS_CTRL:   rd_mux = ctrl_reg;
      OFS_RELOAD: rd_mux = reload_reg;
      OFS_RCTRL:  rd_mux = rctrl_reg;
      OFS_STATUS: rd_mux = {16'h0000, status_reg};
      OFS_FEAT:   rd_mux = {31'h0000_0000, PRESENT};
      OFS_ARCH:   rd_mux = {28'h000_0000, ARCH_REVISION};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end // R8

  always_ff @(posedge clk)
  begin
    if (rst)
      readdata_reg <= 32'h0000_0000;
    else if (avs_read && !ack_reg)
      readdata_reg <= rd_mux;
  end

  // capabilities advertised to software
  always_comb
  begin
    cap_value                             = 32'h0000_0000;
    cap_value[CAP_ON_ACCESS]              = INJECT_ON_ACCESS;
    cap_value[CAP_TYPES_LO +: 3]          = SUPPORTED_TYPES;
    cap_value[CAP_POISON]                 = 1'b1;
    cap_value[CAP_RESTART]                = 1'b1;
    cap_value[CAP_CRIT]                   = 1'b1;
    cap_value[CAP_REPEAT]                 = 1'b1;
  end // R17

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_reg <= CTRL_RST;
    else if (wr_fire && avs_address == OFS_CTRL)
      ctrl_reg <= wmerged & CTRL_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      reload_reg <= RELOAD_RST;
    else if (wr_fire && avs_address == OFS_RELOAD)
      reload_reg <= wmerged;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rctrl_reg <= RCTRL_RST;
    else if (wr_fire && avs_address == OFS_RCTRL)
      rctrl_reg <= wmerged & RCTRL_MASK;
  end

  // countdown engine hookup
  assign logging_on      = !LOGGING_WRITABLE || rctrl_reg[RC_LOG];
  assign cif.run         = ctrl_reg[CTL_RUN];
  assign cif.repeat_on   = ctrl_reg[CTL_REPEAT];
  assign cif.reload      = reload_reg;
  assign cif.enable      = PRESENT && logging_on; // R5
  assign cif.load_pulse  = wr_fire && avs_address == OFS_CTRL && wmerged[CTL_RUN] && !ctrl_reg[CTL_RUN]; // R6
  assign cif.inject_done = ins_go;

  eic_countdown #(
    .W   (CNT_W),
    .DIV (DIV)
  ) u_countdown (
    .clk (clk),
    .rst (rst),
    .cif (cif)
  );

  // request checking: bad selections or combinations inject nothing
  assign sel    = ctrl_reg[SEL_UNC:SEL_CORR];
  assign onehot = $onehot(sel); // R16
  assign req_ok = onehot && (sel & ~SUPPORTED_TYPES) == 3'h0 // R4
               && !(ctrl_reg[CTL_POISON] && sel[SEL_CORR]) // R18
               && !(ctrl_reg[CTL_RESTART] && !sel[SEL_UNC]); // R18

  // injection fires on the next component access or at once
  assign ins_go = cif.in_state && (INJECT_ON_ACCESS ? acc_req : 1'b1); // R13
  assign record = ins_go && req_ok && cif.enable; // R11 R12

  // access path has no data: only the response is faked
  assign acc_ack = acc_req; // R3
  assign acc_err = INJECT_ON_ACCESS && acc_req && record && sel[SEL_UNC] && rctrl_reg[RC_INBAND]; // R2

  // a new injection wins over a software clear in the same cycle
  always_comb
  begin
    status_next = status_reg;
    if (wr_fire && avs_address == OFS_STATUS && avs_byteenable[0] && avs_writedata[ST_VALID])
      status_next = STATUS_RST;
    if (record)
    begin
      status_next[ST_VALID]          = 1'b1; // R15
      status_next[ST_UNC]            = sel[SEL_UNC];
      status_next[ST_POST]           = sel[SEL_POST];
      status_next[ST_KIND_LO +: 2]   = sel[SEL_UNC] ? ctrl_reg[CTL_KIND_LO +: 2] : 2'b00;
      status_next[ST_POISON]         = ctrl_reg[CTL_POISON]; // R17
      status_next[ST_RESTART]        = ctrl_reg[CTL_RESTART];
      status_next[ST_CRIT]           = ctrl_reg[CTL_CRIT];
      if (sel[SEL_CORR] && status_next[ST_CCNT_LO +: CCNT_W] != 8'hff)
        status_next[ST_CCNT_LO +: CCNT_W] = status_next[ST_CCNT_LO +: CCNT_W] + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      status_reg <= STATUS_RST;
    else
      status_reg <= status_next;
  end

  // level interrupts follow the record fields, however they were set
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fault_irq_reg <= 1'b0;
      recov_irq_reg <= 1'b0;
      crit_irq_reg  <= 1'b0;
    end
    else
    begin
      fault_irq_reg <= status_reg[ST_VALID]
                    && ((rctrl_reg[RC_FH_UNC] && (status_reg[ST_UNC] || status_reg[ST_POST]))
                    ||  (rctrl_reg[RC_FH_CORR] && status_reg[ST_CCNT_LO +: CCNT_W] != 8'h00)); // R21 R2
      recov_irq_reg <= status_reg[ST_VALID]
                    && ((rctrl_reg[RC_RECOV_UNC] && status_reg[ST_UNC])
                    ||  (rctrl_reg[RC_RECOV_POST] && status_reg[ST_POST])); // R21 R2
      crit_irq_reg  <= rctrl_reg[RC_CRIT] && status_reg[ST_VALID] && status_reg[ST_CRIT]; // R21 R20
    end
  end

  assign fault_irq = fault_irq_reg;
  assign recov_irq = recov_irq_reg;
  assign crit_irq  = crit_irq_reg;

  a_bus_one_wait: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");

  a_logging_gate: assert property (@(posedge clk) disable iff (rst) // R5
    !logging_on && !wr_fire |=> status_reg == $past(status_reg))
    else $error("record changed while logging is off");

  a_inject_records: assert property (@(posedge clk) disable iff (rst) // R15
    record |=> status_reg[ST_VALID] && status_reg[ST_UNC] == $past(sel[SEL_UNC])
            && status_reg[ST_POST] == $past(sel[SEL_POST]))
    else $error("injected error not recorded as selected");

  a_bad_select: assert property (@(posedge clk) disable iff (rst) // R16
    ins_go && !onehot && !wr_fire |=> status_reg == $past(status_reg))
    else $error("invalid type selection injected something");

  a_poison_corr: assert property (@(posedge clk) disable iff (rst) // R18
    ins_go && ctrl_reg[CTL_POISON] && sel[SEL_CORR] |-> !record)
    else $error("poison injected with a corrected error");

  a_leave_state: assert property (@(posedge clk) disable iff (rst) // R13
    ins_go && (cif.run == 1'b0 || reload_reg == 32'h0 || !ctrl_reg[CTL_REPEAT]) |=> !cif.in_state)
    else $error("injection state held after injecting");

  a_fault_irq: assert property (@(posedge clk) disable iff (rst) // R2
    record && sel[SEL_UNC] && rctrl_reg[RC_FH_UNC] && !wr_fire ##1 !wr_fire |=> fault_irq)
    else $error("fault interrupt missing after injected error");

  a_inband_resp: assert property (@(posedge clk) disable iff (rst) // R2
    acc_err |-> acc_ack && cif.in_state && sel[SEL_UNC])
    else $error("in-band error without uncorrected injection");

  a_inband_gate: assert property (@(posedge clk) disable iff (rst) // R2
    acc_err |-> acc_req && record && rctrl_reg[RC_INBAND])
    else $error("in-band error without access or enable");

  a_inband_given: assert property (@(posedge clk) disable iff (rst) // R2
    INJECT_ON_ACCESS && record && sel[SEL_UNC] && rctrl_reg[RC_INBAND] |-> acc_err)
    else $error("in-band error missing on uncorrected injection");

  a_recov_irq: assert property (@(posedge clk) disable iff (rst) // R2
    record && sel[SEL_UNC] && rctrl_reg[RC_RECOV_UNC] && !wr_fire ##1 !wr_fire |=> recov_irq)
    else $error("recovery interrupt missing after injected error");

  a_crit_level: assert property (@(posedge clk) disable iff (rst) // R21
    rctrl_reg[RC_CRIT] && status_reg[ST_VALID] && status_reg[ST_CRIT] |=> crit_irq)
    else $error("critical interrupt level missing");

  a_irq_drop: assert property (@(posedge clk) disable iff (rst) // R21
    !status_reg[ST_VALID] |=> !fault_irq && !recov_irq && !crit_irq)
    else $error("interrupt raised without a valid record");

  a_ccnt_step: assert property (@(posedge clk) disable iff (rst) // R15
    record && sel[SEL_CORR] && status_reg[ST_CCNT_LO +: CCNT_W] != 8'hff && !wr_fire
    |=> status_reg[ST_CCNT_LO +: CCNT_W] == $past(status_reg[ST_CCNT_LO +: CCNT_W]) + 8'h01)
    else $error("corrected count did not step on injection");

  a_kind_copy: assert property (@(posedge clk) disable iff (rst) // R15
    record && sel[SEL_UNC] |=> status_reg[ST_KIND_LO +: 2] == $past(ctrl_reg[CTL_KIND_LO +: 2]))
    else $error("uncorrected kind not copied from control");

  a_unsupported_type: assert property (@(posedge clk) disable iff (rst) // R4
    ins_go && (sel & ~SUPPORTED_TYPES) != 3'h0 |-> !record)
    else $error("unsupported error type injected");

  a_restart_unc: assert property (@(posedge clk) disable iff (rst) // R18
    ins_go && ctrl_reg[CTL_RESTART] && !sel[SEL_UNC] |-> !record)
    else $error("restartable injected without uncorrected error");

  a_disabled_quiet: assert property (@(posedge clk) disable iff (rst) // R5
    !cif.enable |-> !record && !acc_err)
    else $error("injection while insertion is disabled");

  a_access_only: assert property (@(posedge clk) disable iff (rst) // R13
    INJECT_ON_ACCESS && !acc_req |-> !record)
    else $error("injection fired without a component access");

  a_run_clear_exit: assert property (@(posedge clk) disable iff (rst) // R14
    cif.in_state && !cif.run |=> !cif.in_state)
    else $error("injection state kept after run was cleared");

  a_log_off_exit: assert property (@(posedge clk) disable iff (rst) // R5
    cif.in_state && !cif.enable |=> !cif.in_state)
    else $error("injection state kept while logging is off");
endmodule // eic_fault_inject
`default_nettype wire

// file: verif/tb_eic_fault_inject.sv
// self-checking bench for the fault insertion unit
`timescale 1ns/1ps
`default_nettype none
module tb_eic_fault_inject;
  import eic_pkg::*;
  logic               clk;
  logic               rst;
  logic [ACC_W-1:0]   avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               acc_req;
  logic               acc_ack;
  logic               acc_err;
  logic               fault_irq;
  logic               recov_irq;
  logic               crit_irq;
  logic [31:0]        rd;
  int                 errors;
  int                 samples_checked;
  int                 cycles;

  eic_fault_inject uut (
    .clk             (clk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .acc_req         (acc_req),
    .acc_ack         (acc_ack),
    .acc_err         (acc_err),
    .fault_irq       (fault_irq),
    .recov_irq       (recov_irq),
    .crit_irq        (crit_irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      errors++;
    end
  endtask

  // request held until waitrequest is sampled low, released at that edge
  task automatic bus_cycle(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_cycle(1'b1, a, d, 4'hf);
  endtask

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus_cycle(1'b0, a, 32'h0000_0000, 4'hf);
    check(what, rd, exp);
  endtask

  // one component access; ack and in-band error are same-cycle outputs
  task automatic access(input logic exp_err);
    acc_req <= 1'b1;
    @(posedge clk);
    check("acc_ack", {31'h0, acc_ack}, 32'h1);
    check("acc_err", {31'h0, acc_err}, {31'h0, exp_err});
    acc_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic irqs(input logic [2:0] exp);
    check("irqs", {29'h0, fault_irq, recov_irq, crit_irq}, {29'h0, exp});
  endtask

  // clear record, arm a short countdown, inject on one access, inspect record and irqs
  task automatic inject(input logic [31:0] ctl, input logic [31:0] rc, input logic [31:0] st, input logic err,
                        input logic [2:0] irq);
    wr(OFS_STATUS, 32'h0000_0001);
    wr(OFS_RCTRL, rc);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_RELOAD, 32'h0000_0004);
    wr(OFS_CTRL, ctl | 32'h8000_0000);
    repeat (10) @(posedge clk);
    access(err);
    rd_check("status", OFS_STATUS, st);
    irqs(irq);
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      give_verdict();
    end
  end

  initial
  begin
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    acc_req = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_check("ctrl", OFS_CTRL, CTRL_RST);
    rd_check("reload", OFS_RELOAD, RELOAD_RST);
    rd_check("rctrl", OFS_RCTRL, RCTRL_RST);
    rd_check("status", OFS_STATUS, 32'h0000_0000);
    rd_check("cap", OFS_CAP, 32'h0000_00ff);
    rd_check("feature", OFS_FEAT, 32'h0000_0001);
    rd_check("arch", OFS_ARCH, {28'h0, ARCH_REVISION});
    bus_cycle(1'b1, OFS_CTRL, 32'hffff_ffff, 4'h1);
    rd_check("ctrl lane", OFS_CTRL, 32'h0000_00ff);
    wr(OFS_CTRL, 32'hffff_ffff);
    rd_check("ctrl mask", OFS_CTRL, CTRL_MASK);
    wr(OFS_FEAT, 32'h0000_0000);
    rd_check("feature ro", OFS_FEAT, 32'h0000_0001);
    wr(8'h40, 32'hffff_ffff);
    rd_check("unmapped", 8'h40, 32'h0000_0000);
    inject(32'h0000_0001, 32'h0000_0005, 32'h0000_0101, 1'b0, 3'b100);
    inject(32'h0000_0002, 32'h0000_0013, 32'h0000_0005, 1'b0, 3'b110);
    inject(32'h0000_009c, 32'h0000_004b, 32'h0000_00b3, 1'b1, 3'b110);
    inject(32'h0000_0024, 32'h0000_0021, 32'h0000_000b, 1'b0, 3'b001);
    inject(32'h0000_0003, 32'h0000_007f, 32'h0000_0000, 1'b0, 3'b000);
    inject(32'h0000_0000, 32'h0000_007f, 32'h0000_0000, 1'b0, 3'b000);
    inject(32'h0000_0001, 32'h0000_0004, 32'h0000_0000, 1'b0, 3'b000);
    inject(32'h0000_0009, 32'h0000_0005, 32'h0000_0000, 1'b0, 3'b000);
    // level irq drops once the record is cleared
    inject(32'h0000_0001, 32'h0000_0005, 32'h0000_0101, 1'b0, 3'b100);
    wr(OFS_STATUS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    irqs(3'b000);
    // zero reload never loads the counter
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_RELOAD, 32'h0000_0000);
    wr(OFS_CTRL, 32'h8000_0001);
    repeat (10) @(posedge clk);
    access(1'b0);
    rd_check("status zero reload", OFS_STATUS, 32'h0000_0000);
    // long countdown: early access misses, idle period shows no spontaneous firing
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_RELOAD, 32'h0000_001e);
    wr(OFS_CTRL, 32'h8000_0001);
    repeat (20) @(posedge clk);
    access(1'b0);
    rd_check("status early", OFS_STATUS, 32'h0000_0000);
    repeat (40) @(posedge clk);
    rd_check("status idle", OFS_STATUS, 32'h0000_0000);
    access(1'b0);
    rd_check("status fired", OFS_STATUS, 32'h0000_0101);
    // repeat mode reloads and fires a second time
    wr(OFS_STATUS, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_RELOAD, 32'h0000_0004);
    wr(OFS_CTRL, 32'hc000_0001);
    repeat (10) @(posedge clk);
    access(1'b0);
    repeat (10) @(posedge clk);
    access(1'b0);
    rd_check("status repeat", OFS_STATUS, 32'h0000_0201);
    rd_check("ctrl no counter", OFS_CTRL, 32'hc000_0001);
    // clearing run in the injection state drops the pending injection
    wr(OFS_STATUS, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h8000_0001);
    repeat (10) @(posedge clk);
    wr(OFS_CTRL, 32'h0000_0001);
    access(1'b0);
    rd_check("status run cleared", OFS_STATUS, 32'h0000_0000);
    give_verdict();
  end
endmodule // tb_eic_fault_inject
`default_nettype wire
